/* rtl/ebf_fifo.sv */
`timescale 1ns/1ps
module ebf_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready_o = cnt_q < (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rp_q];
    assign level_o = cnt_q;

    // Storage array, no reset needed
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + AW'(1);
            end
            if (pop) begin
                rp_q <= rp_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : ebf_fifo

/* rtl/ebf_formatter.sv */
`timescale 1ns/1ps
`include "ebf_params.svh"

// Summary of operation
// RULE_01: Every buffer word is 32 bits wide.
// RULE_02: Each event is header, zero or more data words, then trailer.
// RULE_03: Slot code in bits 31..27 of every word but the not-valid one.
// RULE_04: Bits 26..24 give type: 010 header, 000 data, 100 trailer, 110 invalid.
// RULE_05: Header bits 23..16 hold the crate number setting.
// RULE_06: Header bits 13..8 hold the stored channel count.
// RULE_07: Data word bits 20..18 hold the source channel.
// RULE_08: Data bit 17 is range: 0 high, 1 low.
// RULE_09: Data bit 13 set when value is below threshold.
// RULE_10: Below-threshold values kept, flagged, when keep bits are enabled.
// RULE_11: Data bit 12 set when converter overflowed.
// RULE_12: Data bits 11..0 hold the converted value.
// RULE_13: Trailer bits 23..0 hold the 24-bit event counter.
// RULE_14: Reading an empty buffer returns a not-valid word.
// RULE_15: Data follow pair order 0,4,1,5,2,6,3,7, high range first.
// RULE_16: Overflowed, below-threshold or disabled channels are omitted.
// RULE_17: Buffer window is read-only from 0x0000 to 0x07FC.
// RULE_18: A read-only register returns the 16-bit firmware revision.
// RULE_19: Software programs the slot code before chained readout.
// RULE_20: Unassigned bits in header, data and trailer read as zero.
// RULE_21: Each read removes one word, so words come out in order.
module ebf_formatter #(
    parameter logic [15:0] FW_VERSION = `EBF_FW_VER_RST, // Arbitrary value
    parameter int DEPTH = `EBF_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Settings from control registers held elsewhere
    input wire logic [4:0] slot_code_i,
    input wire logic [7:0] crate_num_i,
    input wire logic keep_below_thr_i,
    input wire logic [7:0] chan_enable_i,
    input wire logic [23:0] event_count_i,
    // Converted samples, two per channel, both ranges
    input wire logic conv_valid_i,
    output logic conv_ready_o,
    input wire ebf_pkg::ebf_sample_t [15:0] conv_samples_i,
    // Register read port
    input wire logic rd_i,
    input wire logic [15:0] rd_addr_i,
    output logic [31:0] rd_data_o,
    output logic rd_ack_o
);
    import ebf_pkg::*;

    typedef enum {ST_IDLE, ST_SCAN, ST_HDR, ST_DATA, ST_TRL} ebf_state_t;

    // ****************************************************************
    // Event assembly
    // ****************************************************************
    ebf_state_t state_q;
    ebf_sample_t [15:0] evt_q;
    logic [15:0] keep_q;
    logic [3:0] idx_q;
    logic [5:0] count_q;
    logic [4:0] slot_q;
    ebf_word_t push_word;
    logic push_valid;
    logic push_ready;
    logic [$clog2(DEPTH):0] level;
    logic [5:0] free_words;
    logic [3:0] slot_idx;
    ebf_sample_t cur;

    // Position p: pair p[3:2], member p[0] (0 -> ch, 1 -> ch+4), range p[1]
    // Storage index = 2*channel + range, so both high values of a pair lead
    always_comb begin
        slot_idx = {idx_q[0], idx_q[3:2], idx_q[1]}; // RULE_15
        cur = evt_q[slot_idx];
    end

    // Which samples survive suppression
    logic [15:0] keep_d;
    always_comb begin
        for (int k = 0; k < 16; k++) begin
            keep_d[k] = chan_enable_i[conv_samples_i[k].chan] && !conv_samples_i[k].ovf
                && (!conv_samples_i[k].below_thr || keep_below_thr_i); // RULE_10 RULE_16
        end
    end

    // Whole event fits before starting, so an event of at most DEPTH words never splits on stall
    assign free_words = 6'(DEPTH) - 6'(level);
    assign conv_ready_o = (state_q == ST_IDLE);

    // Word builder, unassigned bits are zero
    always_comb begin
        push_word = '0; // RULE_20
        push_word.slot = slot_q; // RULE_03
        push_valid = 1'b0;
        case (state_q)
            ST_HDR: begin
                push_valid = 1'b1;
                push_word.wtype = `EBF_TYPE_HDR; // RULE_04
                push_word.body[23:16] = crate_num_i; // RULE_05
                push_word.body[13:8] = count_q; // RULE_06
            end
            ST_DATA: begin
                push_valid = keep_q[slot_idx];
                push_word.wtype = `EBF_TYPE_DATA; // RULE_04
                push_word.body[20:18] = cur.chan; // RULE_07
                push_word.body[17] = cur.low_range; // RULE_08
                push_word.body[13] = cur.below_thr; // RULE_09
                push_word.body[12] = cur.ovf; // RULE_11
                push_word.body[11:0] = cur.value; // RULE_12
            end
            ST_TRL: begin
                push_valid = 1'b1;
                push_word.wtype = `EBF_TYPE_TRL; // RULE_04
                push_word.body = event_count_i; // RULE_13
            end
            default: begin
                push_valid = 1'b0;
            end
        endcase
    end

    // Event sequencer
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            evt_q <= '0;
            keep_q <= '0;
            idx_q <= '0;
            count_q <= '0;
            slot_q <= `EBF_SLOT_RST;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (conv_valid_i) begin
                        evt_q <= conv_samples_i;
                        keep_q <= keep_d;
                        count_q <= 6'($countones(keep_d));
                        slot_q <= slot_code_i; // RULE_19
                        state_q <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    // Wait for room; an event larger than the store starts only when empty
                    if (free_words >= count_q + 6'd2 || level == '0) begin
                        idx_q <= '0;
                        state_q <= ST_HDR; // RULE_02
                    end
                end
                ST_HDR: begin
                    if (push_ready) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (!push_valid || push_ready) begin
                        idx_q <= idx_q + 4'd1;
                        if (idx_q == 4'hF) begin
                            state_q <= ST_TRL;
                        end
                    end
                end
                ST_TRL: begin
                    if (push_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Event store and read port
    // ****************************************************************
    ebf_word_t pop_word;
    ebf_word_t invalid_word;
    logic pop_valid;
    logic in_win;
    logic is_fw;

    ebf_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_store (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_word), // RULE_01
        .out_valid_o(pop_valid),
        .out_ready_i(rd_i && in_win), // RULE_21
        .out_data_o(pop_word),
        .level_o(level)
    );

    assign in_win = rd_addr_i <= `EBF_WIN_LAST && rd_addr_i[1:0] == 2'b00; // RULE_17
    assign is_fw = rd_addr_i == `EBF_FW_VER_OFF;

    always_comb begin
        invalid_word = '0;
        invalid_word.wtype = `EBF_TYPE_INVALID; // RULE_14
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data_o <= '0;
            rd_ack_o <= 1'b0;
        end else begin
            rd_ack_o <= rd_i;
            if (rd_i && in_win) begin
                rd_data_o <= pop_valid ? pop_word : invalid_word; // RULE_14 RULE_21
            end else if (rd_i && is_fw) begin
                rd_data_o <= {16'h0000, FW_VERSION}; // RULE_18
            end else if (rd_i) begin
                rd_data_o <= '0;
            end
        end
    end

endmodule : ebf_formatter

/* rtl/ebf_params.svh */
`ifndef EBF_PARAMS_SVH
`define EBF_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define EBF_WIN_FIRST 16'h0000
`define EBF_WIN_LAST 16'h07FC
`define EBF_FW_VER_OFF 16'h1000

// ****************************************************************
// Word type codes, bits 26..24
// ****************************************************************
`define EBF_TYPE_HDR 3'h2
`define EBF_TYPE_DATA 3'h0
`define EBF_TYPE_TRL 3'h4
`define EBF_TYPE_INVALID 3'h6

// ****************************************************************
// Reset values and misc
// ****************************************************************
`define EBF_SLOT_RST 5'h1F
`define EBF_CRATE_RST 8'h00
`define EBF_NCHAN 8
`define EBF_FIFO_DEPTH 16
`define EBF_FW_VER_RST 16'h0000

`endif

/* rtl/ebf_pkg.sv */
package ebf_pkg;

    // Packed word of the output buffer, 32 bits wide
    typedef struct packed {
        logic [4:0] slot;
        logic [2:0] wtype;
        logic [23:0] body;
    } ebf_word_t;

    // One converted sample offered by the front end
    typedef struct packed {
        logic [2:0] chan;
        logic low_range;
        logic below_thr;
        logic ovf;
        logic [11:0] value;
    } ebf_sample_t;

endpackage : ebf_pkg

/* verif/ebf_formatter_sva.sv */
`timescale 1ns/1ps
// ********************
// Readout and conversion port checks
// ********************
module ebf_formatter_sva #(
    parameter logic [15:0] FW_VERSION = 16'h0000
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [4:0] slot_code_i,
    input wire logic [7:0] crate_num_i,
    input wire logic conv_valid_i,
    input wire logic conv_ready_o,
    input wire logic rd_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic [31:0] rd_data_o,
    input wire logic rd_ack_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    logic win_q;
    logic hit;
    logic [2:0] wtype;
    // Remember whether the read in flight hit the buffer window
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            win_q <= 1'b0;
        end else if (rd_i) begin
            win_q <= (rd_addr_i <= 16'h07FC) && (rd_addr_i[1:0] == 2'b00);
        end
    end
    // Answered window word and its type field
    assign hit = rd_ack_o && win_q;
    assign wtype = rd_data_o[26:24];
    sequence s_take;
        conv_valid_i && conv_ready_o;
    endsequence
    sequence s_fw_read;
        rd_i && rd_addr_i == 16'h1000;
    endsequence
    AST_ACK_NEXT: assert property (rd_i |=> rd_ack_o)
        else $error("read not answered next cycle");
    AST_ACK_CAUSE: assert property (rd_ack_o |-> $past(rd_i))
        else $error("answer without a read");
    AST_FW_VALUE: assert property (s_fw_read |=> rd_data_o == {16'h0000, FW_VERSION})
        else $error("wrong revision word");
    AST_UNMAPPED: assert property (rd_i && rd_addr_i > 16'h07FC && rd_addr_i != 16'h1000
        |=> rd_data_o == 32'h0000_0000) else $error("unmapped read not zero");
    AST_TYPE_LEGAL: assert property (hit |-> wtype inside {3'h0, 3'h2, 3'h4, 3'h6})
        else $error("reserved word type");
    AST_NOT_VALID: assert property (hit && wtype == 3'h6 |-> rd_data_o == 32'h0600_0000)
        else $error("bad not-valid word");
    AST_SLOT_CODE: assert property (hit && wtype != 3'h6 |-> rd_data_o[31:27] == slot_code_i)
        else $error("slot code missing");
    AST_HEADER: assert property (hit && wtype == 3'h2 |-> rd_data_o[23:16] == crate_num_i
        && rd_data_o[15:14] == 2'h0 && rd_data_o[7:0] == 8'h00 && rd_data_o[13:8] <= 6'h10)
        else $error("bad header word");
    AST_DATA_ZERO: assert property (hit && wtype == 3'h0
        |-> rd_data_o[23:21] == 3'h0 && rd_data_o[16:14] == 3'h0) else $error("bad data word");
    AST_BUSY_AFTER_TAKE: assert property (s_take |=> (!conv_ready_o) [*3])
        else $error("ready during event build");
endmodule : ebf_formatter_sva

/* verif/ebf_reader_model.sv */
`timescale 1ns/1ps
// ********************
// Readout master model
// ********************
module ebf_reader_model (
    input wire logic sys_clk_i,
    output logic rd_o,
    output logic [15:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_ack_i
);
    // Idle bus at time zero
    initial begin
        rd_o = 1'b0;
        rd_addr_o = 16'hFFFF;
    end
    // One read; gap+1 idle cycles first so the reader can be prompt or slow
    task automatic read(input logic [15:0] addr, input int gap, output logic [31:0] data);
        data = 'x;
        repeat (gap + 1) @(posedge sys_clk_i);
        rd_o <= 1'b1;
        rd_addr_o <= addr;
        @(posedge sys_clk_i);
        rd_o <= 1'b0;
        rd_addr_o <= ~addr; // Released address stops showing the old value
        repeat (4) begin
            @(posedge sys_clk_i);
            if (rd_ack_i === 1'b1) begin
                data = rd_data_i;
                break;
            end
        end
    endtask : read
endmodule : ebf_reader_model

/* verif/tb_event_buffer_readout_formatter.sv */
`timescale 1ns/1ps
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb_event_buffer_readout_formatter;
    import ebf_pkg::*;
    localparam logic [15:0] FW = 16'h5A3C; // Arbitrary revision value
    localparam logic [4:0] SLOT = 5'h0B;
    localparam logic [7:0] CRATE = 8'hC3;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic keep = 1'b0;
    logic [7:0] en = 8'hFF;
    logic [23:0] evcnt = 24'h00_0000;
    logic cvalid = 1'b0;
    logic cready;
    ebf_sample_t [15:0] smp = '0;
    logic rd;
    logic [15:0] addr;
    logic [31:0] rdata;
    logic ack;
    logic [31:0] got;
    logic [31:0] exp_q[$];
    int failures = 0;
    int check_count = 0;
    int taken = 0;
    // Free-running 4 ns clock
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Slot code fixed before any readout so every word can be attributed
    ebf_formatter #(.FW_VERSION(FW)) DUT (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .slot_code_i(SLOT),
        .crate_num_i(CRATE), .keep_below_thr_i(keep), .chan_enable_i(en),
        .event_count_i(evcnt), .conv_valid_i(cvalid), .conv_ready_o(cready),
        .conv_samples_i(smp), .rd_i(rd), .rd_addr_i(addr), .rd_data_o(rdata), .rd_ack_o(ack));
    ebf_reader_model u_host (.sys_clk_i(sys_clk_i), .rd_o(rd), .rd_addr_o(addr),
        .rd_data_i(rdata), .rd_ack_i(ack));
    // Drop valid on the edge that hands the event over
    always @(posedge sys_clk_i) begin
        if (cvalid && cready) begin
            cvalid <= 1'b0;
            taken++;
        end
    end
    task automatic report_and_stop();
        if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // Stage one event and queue the words it should leave in the store
    task automatic send_ev(input logic [7:0] e, input logic k, input logic [23:0] c,
        input logic [15:0] ovf, input logic [15:0] blw);
        logic [31:0] d[$];
        int i;
        @(posedge sys_clk_i);
        for (int j = 0; j < 16; j++)
            smp[j] <= {3'(j / 2), j[0], blw[j], ovf[j], 12'(12'h111 * j)};
        en <= e;
        keep <= k;
        evcnt <= c;
        cvalid <= 1'b1;
        @(negedge sys_clk_i);
        for (int p = 0; p < 16; p++) begin
            i = 2 * (p / 4 + 4 * p[0]) + p[1];
            if (e[i / 2] && !ovf[i] && (k || !blw[i]))
                d.push_back({SLOT, 3'h0, 3'h0, 3'(i / 2), i[0], 3'h0, blw[i], ovf[i],
                    12'(12'h111 * i)});
        end
        exp_q.push_back({SLOT, 3'h2, CRATE, 2'h0, 6'(d.size()), 8'h00});
        exp_q = {exp_q, d};
        exp_q.push_back({SLOT, 3'h4, c});
    endtask : send_ev
    // Bounded wait until the event is taken and its trailer stored
    task automatic wait_idle(input int n);
        for (int c = 0; c < n && (cvalid !== 1'b0 || cready !== 1'b1); c++)
            @(negedge sys_clk_i);
    endtask : wait_idle
    // Read n words, gap+2 idle cycles apart, across the window
    task automatic drain(input int n, input int gap);
        logic [31:0] x;
        for (int j = 0; j < n; j++) begin
            u_host.read(16'h07FC - 16'(4 * j), gap, got);
            x = exp_q.pop_front();
            `CHK(got, x)
        end
    endtask : drain
    // Empty window, revision register and unmapped space
    task automatic t_registers();
        u_host.read(16'h0000, 0, got);
        `CHK(got, 32'h0600_0000)
        u_host.read(16'h07FC, 1, got);
        `CHK(got, 32'h0600_0000)
        u_host.read(16'h1000, 0, got);
        `CHK(got, {16'h0000, FW})
        u_host.read(16'h0800, 0, got);
        `CHK(got, 32'h0000_0000)
    endtask : t_registers
    // Fill the store exactly, second event taken but parked, drain while it waits
    task automatic t_fill();
        send_ev(8'hF7, 1'b0, 24'h00_0001, 16'h0000, 16'h0000);
        wait_idle(100);
        send_ev(8'h7F, 1'b1, 24'h00_0002, 16'h2000, 16'h0012);
        repeat (30) @(negedge sys_clk_i);
        `CHK(taken, 2)
        `CHK(cready, 1'b0)
        drain(16, 3);
        wait_idle(200);
        `CHK(taken, 2)
        drain(15, 0);
    endtask : t_fill
    // Below-threshold dropped, then an event with no channel words
    task automatic t_suppress();
        send_ev(8'hFF, 1'b0, 24'hFF_FFFF, 16'h2000, 16'h0012);
        wait_idle(100);
        drain(15, 0);
        send_ev(8'h00, 1'b0, 24'h00_0000, 16'h0000, 16'h0000);
        wait_idle(100);
        drain(2, 0);
        u_host.read(16'h0004, 0, got);
        `CHK(got, 32'h0600_0000)
    endtask : t_suppress
    // Reset for 16 cycles, then the scenarios in turn
    initial begin
        repeat (16) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        t_registers();
        t_fill();
        t_suppress();
        report_and_stop();
    end
    // Cut a hang short well past the expected run
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        failures++;
        report_and_stop();
    end
endmodule : tb_event_buffer_readout_formatter
bind ebf_formatter ebf_formatter_sva #(.FW_VERSION(FW_VERSION)) u_sva (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .slot_code_i(slot_code_i),
    .crate_num_i(crate_num_i), .conv_valid_i(conv_valid_i), .conv_ready_o(conv_ready_o),
    .rd_i(rd_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o));
